// [rtl/aesp_pkg.sv]
// Shared constants and types of the axis encoder, status and parameter block.
package aesp_pkg;

  // --------------------------------------------------------------------------
  // Parameter numbers
  // --------------------------------------------------------------------------
  localparam logic [7:0] P_BOOST = 8'hC8;
  localparam logic [7:0] P_NULL_CFG = 8'hC9;
  localparam logic [7:0] P_FREEWHEEL = 8'hCC;
  localparam logic [7:0] P_LOAD = 8'hCE;
  localparam logic [7:0] P_XERR = 8'hCF;
  localparam logic [7:0] P_DRV_FLT = 8'hD0;
  localparam logic [7:0] P_IENC = 8'hD1;
  localparam logic [7:0] P_ISCALE = 8'hD2;
  localparam logic [7:0] P_IDEV = 8'hD4;
  localparam logic [7:0] P_STBY = 8'hD6;
  localparam logic [7:0] P_ANGLE = 8'hD7;
  localparam logic [7:0] P_XENC = 8'hD8;
  localparam logic [7:0] P_XSCALE = 8'hD9;

  // --------------------------------------------------------------------------
  // Values after reset and field positions
  // --------------------------------------------------------------------------
  localparam logic [15:0] STBY_RST = 16'h00C8;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int XERR_STALL_BIT = 0;
  localparam int XERR_DEV_BIT = 1;
  localparam int FLT_STALL_BIT = 0;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int STILL_CYCLES = 2 ** 20;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] spare;
    logic pol_high;
    logic every;
    logic clr_en;
  } aesp_null_cfg_t;

  typedef struct packed {
    logic [9:0] angle;
    logic [9:0] load;
    logic [6:0] fault;
    logic step;
    logic [1:0] iq;
    logic xn;
    logic [1:0] xq;
  } aesp_pins_t;

  localparam int PIN_W = $bits(aesp_pins_t);

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_STBY = 2'b01,
    PWR_FREE = 2'b10
  } aesp_pwr_t;

endpackage

// [rtl/aesp_axis_params.sv]
// Axis parameter set: currents, encoders, fault flags and deviation monitor.

// Summary of operation
// - Boost current while ramping, run current if zero.
// - Null config picks clear next or every event.
// - Config bit makes null channel active high.
// - Cut power after idle freewheel time; zero never.
// - Read-only load value, same as stall measurement.
// - Error value: 1 stall, 2 deviation.
// - Error flags clear on read or motion.
// - Fault bits 0-2: stall, overtemp, prewarning.
// - Fault bits 3-4: coil short to ground.
// - Fault bits 5-6: coil open load.
// - Fault bit 7: no step for 2^20 cycles.
// - Stop motor on excess deviation; zero disables.
// - Standby current after power down delay, default 200.
// - Read-only internal encoder angle, 0 to 1023.
module aesp_axis_params #(
  parameter int TICK_CYC = aesp_pkg::TICK_CYCLES,
  parameter int STILL_CYC = aesp_pkg::STILL_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Parameter access
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic [7:0] PAR_NUM,
  input wire logic [31:0] PAR_WDATA,
  output logic [31:0] PAR_RDATA,
  output logic PAR_ACK,
  output logic PAR_BAD,
  // Motion controller
  input wire logic RAMPING,
  input wire logic VEL_ZERO,
  input wire logic MOTION_CMD,
  input wire logic [7:0] RUN_CURRENT,
  input wire logic [31:0] ACTUAL_POS,
  // Pins from driver and encoders
  input wire logic [6:0] DRV_FAULT,
  input wire logic [9:0] DRV_LOAD,
  input wire logic [9:0] ROTOR_ANGLE,
  input wire logic STEP_IN,
  input wire logic INT_ENC_A,
  input wire logic INT_ENC_B,
  input wire logic EXT_ENC_A,
  input wire logic EXT_ENC_B,
  input wire logic EXT_ENC_N,
  // Driver controls
  output logic [7:0] CURRENT_SCALE,
  output logic STANDBY_CURRENT,
  output logic MOTOR_POWER_OFF,
  output logic MOTOR_STOP
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Quadrature step: bit 1 flags a legal single edge, bit 0 says count up.
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [1:0] r;
    r = 2'b00;
    if ((prev[1] ^ cur[1]) != (prev[0] ^ cur[0]))
    begin
      r = {1'b1, prev[1] ^ cur[0]};
    end
    return r;
  endfunction

  function automatic logic [31:0] quad_count(input logic [31:0] c, input logic [1:0] s);
    logic [31:0] r;
    r = c;
    if (s[1])
    begin
      r = s[0] ? c + 32'h0000_0001 : c - 32'h0000_0001;
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  aesp_pkg::aesp_pins_t pins_raw;
  logic [aesp_pkg::PIN_W-1:0] s1_reg;
  logic [aesp_pkg::PIN_W-1:0] s2_reg;
  logic [aesp_pkg::PIN_W-1:0] s3_reg;
  logic [aesp_pkg::PIN_W-1:0] filt_reg;
  aesp_pkg::aesp_pins_t pin;

  assign pins_raw = '{angle: ROTOR_ANGLE, load: DRV_LOAD, fault: DRV_FAULT, step: STEP_IN,
                      iq: {INT_ENC_A, INT_ENC_B}, xn: EXT_ENC_N, xq: {EXT_ENC_A, EXT_ENC_B}};
  assign pin = filt_reg;

  // Each pin takes three stages; a change is accepted once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < aesp_pkg::PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_N)
        begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          filt_reg[gi] <= 1'b0;
        end
        else
        begin
          s1_reg[gi] <= pins_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          filt_reg[gi] <= (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Parameter registers and encoders
  // --------------------------------------------------------------------------
  logic [7:0] boost_reg, boost_next;
  aesp_pkg::aesp_null_cfg_t ncfg_reg, ncfg_next;
  logic [15:0] free_reg, free_next;
  logic [15:0] stby_reg, stby_next;
  logic [31:0] ienc_reg, ienc_next;
  logic [31:0] iscale_reg, iscale_next;
  logic [31:0] idev_reg, idev_next;
  logic [31:0] xenc_reg, xenc_next;
  logic [31:0] xscale_reg, xscale_next;
  logic [1:0] xerr_reg, xerr_next;
  logic stop_reg, stop_next;
  logic [1:0] iq_prev_reg, xq_prev_reg;
  logic null_prev_reg, stall_prev_reg;
  logic null_act, null_evt, stall_evt, dev_evt;
  logic [32:0] diff;
  logic [31:0] diff_abs;

  // Null channel level after polarity selection, and its activating edge.
  assign null_act = ncfg_reg.pol_high ? pin.xn : ~pin.xn;
  assign null_evt = null_act & ~null_prev_reg;
  assign stall_evt = pin.fault[aesp_pkg::FLT_STALL_BIT] & ~stall_prev_reg;
  // The difference is taken one bit wider so that a large gap between the signed counts cannot overflow it.
  assign diff = {ACTUAL_POS[31], ACTUAL_POS} - {ienc_reg[31], ienc_reg};
  assign diff_abs = diff[32] ? 32'(-diff) : diff[31:0];
  assign dev_evt = (idev_reg != 32'h0000_0000) && (diff_abs > idev_reg);

  // Host writes, encoder counting, null clearing and error flag bookkeeping.
  always_comb
  begin
    boost_next = boost_reg;
    ncfg_next = ncfg_reg;
    free_next = free_reg;
    stby_next = stby_reg;
    iscale_next = iscale_reg;
    idev_next = idev_reg;
    xscale_next = xscale_reg;
    ienc_next = quad_count(ienc_reg, quad_step(iq_prev_reg, pin.iq));
    xenc_next = quad_count(xenc_reg, quad_step(xq_prev_reg, pin.xq));
    xerr_next = xerr_reg;
    stop_next = stop_reg;
    if (null_evt && ncfg_reg.clr_en)
    begin
      xenc_next = 32'h0000_0000;
      if (!ncfg_reg.every)
      begin
        ncfg_next.clr_en = 1'b0;
      end
    end
    if (PAR_WR)
    begin
      if (PAR_NUM == aesp_pkg::P_BOOST)
        boost_next = PAR_WDATA[7:0];
      else if (PAR_NUM == aesp_pkg::P_NULL_CFG)
        ncfg_next = PAR_WDATA[4:0];
      else if (PAR_NUM == aesp_pkg::P_FREEWHEEL)
        free_next = PAR_WDATA[15:0];
      else if (PAR_NUM == aesp_pkg::P_IENC)
        ienc_next = PAR_WDATA;
      else if (PAR_NUM == aesp_pkg::P_ISCALE)
        iscale_next = PAR_WDATA;
      else if (PAR_NUM == aesp_pkg::P_IDEV)
        idev_next = {1'b0, PAR_WDATA[30:0]};
      else if (PAR_NUM == aesp_pkg::P_STBY)
        stby_next = PAR_WDATA[15:0];
      else if (PAR_NUM == aesp_pkg::P_XENC)
        xenc_next = PAR_WDATA;
      else if (PAR_NUM == aesp_pkg::P_XSCALE)
        xscale_next = PAR_WDATA;
    end
    // Clearing comes first so that an event in the same cycle still lands.
    if ((PAR_RD && PAR_NUM == aesp_pkg::P_XERR) || MOTION_CMD)
    begin
      xerr_next = 2'b00;
      stop_next = 1'b0;
    end
    if (stall_evt)
    begin
      xerr_next[aesp_pkg::XERR_STALL_BIT] = 1'b1;
    end
    if (dev_evt)
    begin
      xerr_next[aesp_pkg::XERR_DEV_BIT] = 1'b1;
      stop_next = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      boost_reg <= aesp_pkg::BYTE_RST;
      ncfg_reg <= '0;
      free_reg <= aesp_pkg::HALF_RST;
      stby_reg <= aesp_pkg::STBY_RST;
      ienc_reg <= aesp_pkg::WORD_RST;
      iscale_reg <= aesp_pkg::WORD_RST;
      idev_reg <= aesp_pkg::WORD_RST;
      xenc_reg <= aesp_pkg::WORD_RST;
      xscale_reg <= aesp_pkg::WORD_RST;
      xerr_reg <= 2'b00;
      stop_reg <= 1'b0;
      iq_prev_reg <= 2'b00;
      xq_prev_reg <= 2'b00;
      null_prev_reg <= 1'b0;
      stall_prev_reg <= 1'b0;
    end
    else
    begin
      boost_reg <= boost_next;
      ncfg_reg <= ncfg_next;
      free_reg <= free_next;
      stby_reg <= stby_next;
      ienc_reg <= ienc_next;
      iscale_reg <= iscale_next;
      idev_reg <= idev_next;
      xenc_reg <= xenc_next;
      xscale_reg <= xscale_next;
      xerr_reg <= xerr_next;
      stop_reg <= stop_next;
      iq_prev_reg <= pin.iq;
      xq_prev_reg <= pin.xq;
      null_prev_reg <= null_act;
      stall_prev_reg <= pin.fault[aesp_pkg::FLT_STALL_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Idle timing, standstill and current selection
  // --------------------------------------------------------------------------
  logic [31:0] tick_reg, tick_next;
  logic [15:0] idle_reg, idle_next;
  logic [20:0] still_reg, still_next;
  logic step_prev_reg;
  aesp_pkg::aesp_pwr_t pwr_reg, pwr_next;
  logic [7:0] cur_reg, cur_next;
  logic stby_out_reg, stby_out_next, off_out_reg, off_out_next;

  // Idle time counts in 10 ms ticks and saturates, so very long pauses stay decided.
  always_comb
  begin
    tick_next = tick_reg + 32'h0000_0001;
    idle_next = idle_reg;
    still_next = (still_reg < 21'(STILL_CYC)) ? still_reg + 21'h00_0001 : still_reg;
    pwr_next = pwr_reg;
    if (tick_reg >= 32'(TICK_CYC - 1))
    begin
      tick_next = 32'h0000_0000;
      if (idle_reg != 16'hFFFF)
        idle_next = idle_reg + 16'h0001;
    end
    if (!VEL_ZERO)
    begin
      tick_next = 32'h0000_0000;
      idle_next = 16'h0000;
    end
    if (pin.step & ~step_prev_reg)
    begin
      still_next = 21'h00_0000;
    end
    case (pwr_reg)
      aesp_pkg::PWR_RUN:
        if (VEL_ZERO && idle_reg >= stby_reg)
          pwr_next = aesp_pkg::PWR_STBY;
      aesp_pkg::PWR_STBY:
        if (!VEL_ZERO)
          pwr_next = aesp_pkg::PWR_RUN;
        else if (free_reg != 16'h0000 && idle_reg >= free_reg)
          pwr_next = aesp_pkg::PWR_FREE;
      aesp_pkg::PWR_FREE:
        if (!VEL_ZERO)
          pwr_next = aesp_pkg::PWR_RUN;
      default:
        pwr_next = aesp_pkg::PWR_RUN;
    endcase
    // A freewheel time shorter than the standby delay still cuts power on time.
    if (pwr_reg == aesp_pkg::PWR_RUN && VEL_ZERO && free_reg != 16'h0000 && idle_reg >= free_reg)
      pwr_next = aesp_pkg::PWR_FREE;
    cur_next = (RAMPING && boost_reg != 8'h00) ? boost_reg : RUN_CURRENT;
    // Power outputs follow the next state, so they leave flip-flops in step with it.
    stby_out_next = (pwr_next == aesp_pkg::PWR_STBY);
    off_out_next = (pwr_next == aesp_pkg::PWR_FREE);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      tick_reg <= aesp_pkg::WORD_RST;
      idle_reg <= aesp_pkg::HALF_RST;
      still_reg <= 21'h00_0000;
      step_prev_reg <= 1'b0;
      pwr_reg <= aesp_pkg::PWR_RUN;
      cur_reg <= aesp_pkg::BYTE_RST;
      stby_out_reg <= 1'b0;
      off_out_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
      idle_reg <= idle_next;
      still_reg <= still_next;
      step_prev_reg <= pin.step;
      pwr_reg <= pwr_next;
      cur_reg <= cur_next;
      stby_out_reg <= stby_out_next;
      off_out_reg <= off_out_next;
    end
  end

  // --------------------------------------------------------------------------
  // Readout
  // --------------------------------------------------------------------------
  logic [7:0] flt;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, bad_reg, bad_next;

  // Driver flags pass straight through; only standstill is made here.
  assign flt = {still_reg >= 21'(STILL_CYC), pin.fault};

  always_comb
  begin
    rdata_next = rdata_reg;
    bad_next = 1'b0;
    if (PAR_RD)
    begin
      if (PAR_NUM == aesp_pkg::P_BOOST)
        rdata_next = {24'h00_0000, boost_reg};
      else if (PAR_NUM == aesp_pkg::P_NULL_CFG)
        rdata_next = {27'h000_0000, ncfg_reg};
      else if (PAR_NUM == aesp_pkg::P_FREEWHEEL)
        rdata_next = {16'h0000, free_reg};
      else if (PAR_NUM == aesp_pkg::P_LOAD)
        rdata_next = {22'h00_0000, pin.load};
      else if (PAR_NUM == aesp_pkg::P_XERR)
        rdata_next = {30'h0000_0000, xerr_reg};
      else if (PAR_NUM == aesp_pkg::P_DRV_FLT)
        rdata_next = {24'h00_0000, flt};
      else if (PAR_NUM == aesp_pkg::P_IENC)
        rdata_next = ienc_reg;
      else if (PAR_NUM == aesp_pkg::P_ISCALE)
        rdata_next = iscale_reg;
      else if (PAR_NUM == aesp_pkg::P_IDEV)
        rdata_next = idev_reg;
      else if (PAR_NUM == aesp_pkg::P_STBY)
        rdata_next = {16'h0000, stby_reg};
      else if (PAR_NUM == aesp_pkg::P_ANGLE)
        rdata_next = {22'h00_0000, pin.angle};
      else if (PAR_NUM == aesp_pkg::P_XENC)
        rdata_next = xenc_reg;
      else if (PAR_NUM == aesp_pkg::P_XSCALE)
        rdata_next = xscale_reg;
      else
      begin
        rdata_next = 32'h0000_0000;
        bad_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      rdata_reg <= aesp_pkg::WORD_RST;
      ack_reg <= 1'b0;
      bad_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ack_reg <= PAR_RD | PAR_WR;
      bad_reg <= bad_next;
    end
  end

  assign PAR_RDATA = rdata_reg;
  assign PAR_ACK = ack_reg;
  assign PAR_BAD = bad_reg;
  assign CURRENT_SCALE = cur_reg;
  assign STANDBY_CURRENT = stby_out_reg;
  assign MOTOR_POWER_OFF = off_out_reg;
  assign MOTOR_STOP = stop_reg;

endmodule

// [verif/aesp_axis_monitor.sv]
// Checker of the axis parameter block, bound to its top-level ports.
module aesp_axis_monitor (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Parameter access
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic [7:0] PAR_NUM,
  input wire logic [31:0] PAR_RDATA,
  input wire logic PAR_ACK,
  input wire logic PAR_BAD,
  // Motion side and driver controls
  input wire logic RAMPING,
  input wire logic VEL_ZERO,
  input wire logic MOTION_CMD,
  input wire logic [7:0] RUN_CURRENT,
  input wire logic [7:0] CURRENT_SCALE,
  input wire logic STANDBY_CURRENT,
  input wire logic MOTOR_POWER_OFF,
  input wire logic MOTOR_STOP
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // --------
  // Access handshake
  // --------
  // Every request is answered exactly one cycle later, and never otherwise.
  ack_follows_req_a: assert property ((PAR_WR || PAR_RD) |=> PAR_ACK)
    else $error("acknowledge missing");
  ack_no_extra_a: assert property (!(PAR_WR || PAR_RD) |=> !PAR_ACK)
    else $error("acknowledge without request");
  bad_with_ack_a: assert property (PAR_BAD |-> PAR_ACK)
    else $error("bad number flag without acknowledge");

  // --------
  // Read value widths
  // --------
  // Narrow values must leave the upper bits of the read word clear.
  property narrow_p(logic [7:0] n, int w);
    (PAR_RD && PAR_NUM == n) |=> (PAR_RDATA >> w) == 32'h0;
  endproperty
  load_width_a: assert property (narrow_p(aesp_pkg::P_LOAD, 10))
    else $error("load value too wide");
  xerr_width_a: assert property (narrow_p(aesp_pkg::P_XERR, 2))
    else $error("error flags too wide");
  fault_width_a: assert property (narrow_p(aesp_pkg::P_DRV_FLT, 8))
    else $error("fault flags too wide");
  angle_width_a: assert property (narrow_p(aesp_pkg::P_ANGLE, 10))
    else $error("angle value too wide");

  // --------
  // Current, power and stop
  // --------
  // Outside ramps the scale follows the run current one cycle late.
  run_current_a: assert property (!RAMPING |=> CURRENT_SCALE == $past(RUN_CURRENT))
    else $error("run current not applied");
  motion_run_a: assert property (!VEL_ZERO |=> !STANDBY_CURRENT && !MOTOR_POWER_OFF)
    else $error("reduced power while moving");
  power_off_idle_a: assert property (MOTOR_POWER_OFF |-> !STANDBY_CURRENT && $past(VEL_ZERO))
    else $error("power cut without standstill");
  stop_holds_a: assert property (MOTOR_STOP && !MOTION_CMD &&
    !(PAR_RD && PAR_NUM == aesp_pkg::P_XERR) |=> MOTOR_STOP)
    else $error("motor stop dropped by itself");

  // Main scenarios seen at least once.
  cover property (MOTOR_STOP);
  cover property ($rose(MOTOR_POWER_OFF));
  cover property ($rose(STANDBY_CURRENT));
  cover property (PAR_BAD);
endmodule

bind aesp_axis_params aesp_axis_monitor mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .PAR_WR(PAR_WR), .PAR_RD(PAR_RD), .PAR_NUM(PAR_NUM), .PAR_RDATA(PAR_RDATA),
  .PAR_ACK(PAR_ACK), .PAR_BAD(PAR_BAD), .RAMPING(RAMPING), .VEL_ZERO(VEL_ZERO),
  .MOTION_CMD(MOTION_CMD), .RUN_CURRENT(RUN_CURRENT), .CURRENT_SCALE(CURRENT_SCALE),
  .STANDBY_CURRENT(STANDBY_CURRENT), .MOTOR_POWER_OFF(MOTOR_POWER_OFF),
  .MOTOR_STOP(MOTOR_STOP));

// [verif/aesp_drv_model.sv]
// Behavioural model of the motor driver, motor and encoders at the pins.
module aesp_drv_model (
  // Clock
  input wire logic CORE_CLK,
  // Pins towards the block
  output aesp_pkg::aesp_pins_t PINS
);
  timeunit 1ns;
  timeprecision 1ns;
  aesp_pkg::aesp_pins_t p;
  assign PINS = p;
  initial p = '0;

  // Pins move at falling edges and are held six cycles, longer than the input filter.
  task automatic hold_pin();
    repeat (6) @(negedge CORE_CLK);
  endtask

  // One pulse on the step input.
  task automatic step_pulse();
    p.step = 1'b1;
    hold_pin();
    p.step = 1'b0;
    hold_pin();
  endtask

  // Forward quadrature edges, B leading A, on the internal or external encoder.
  task automatic quad(input int n, input bit ext);
    int i;
    for (i = 1; i <= n; i++)
    begin
      if (ext)
        p.xq = 2'((i % 4) ^ ((i % 4) >> 1));
      else
        p.iq = 2'((i % 4) ^ ((i % 4) >> 1));
      hold_pin();
    end
  endtask

  // Null channel pulse at the given active level, idle at the other.
  task automatic null_pulse(input logic act);
    p.xn = act;
    hold_pin();
    p.xn = !act;
    hold_pin();
  endtask
endmodule

// [verif/aesp_axis_params_test.sv]
// Self-checking bench of the axis parameter block.
module aesp_axis_params_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic par_wr = 1'b0;
  logic par_rd = 1'b0;
  logic ramping = 1'b0, vel_zero = 1'b0, motion_cmd = 1'b0;
  logic [7:0] par_num = 8'h00;
  logic [7:0] run_current = 8'h20;
  logic [31:0] par_wdata = 32'h0, actual_pos = 32'h0;
  logic [31:0] par_rdata, rd_val;
  logic par_ack, par_bad, rd_bad, standby_current, motor_power_off, motor_stop;
  logic [7:0] current_scale;
  aesp_pkg::aesp_pins_t pins;
  int fail_count = 0, compares = 0, cycles = 0, i;
  logic [7:0] rw_num [9] = '{aesp_pkg::P_BOOST, aesp_pkg::P_NULL_CFG, aesp_pkg::P_FREEWHEEL,
    aesp_pkg::P_IENC, aesp_pkg::P_ISCALE, aesp_pkg::P_IDEV, aesp_pkg::P_STBY,
    aesp_pkg::P_XENC, aesp_pkg::P_XSCALE};
  logic [31:0] rw_mask [9] = '{32'hFF, 32'h1F, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'h7FFFFFFF, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [7:0] ro_num [4] = '{aesp_pkg::P_LOAD, aesp_pkg::P_XERR, aesp_pkg::P_DRV_FLT,
    aesp_pkg::P_ANGLE};
  logic [31:0] ro_exp [4] = '{32'h0, 32'h0, 32'h80, 32'h0};

  always #10 core_clk = ~core_clk;

  // Short counts keep the tick and standstill timing within a brief run.
  aesp_axis_params #(.TICK_CYC(10), .STILL_CYC(32)) uut (.CORE_CLK(core_clk), .RST_N(rst_n),
    .PAR_WR(par_wr), .PAR_RD(par_rd), .PAR_NUM(par_num), .PAR_WDATA(par_wdata),
    .PAR_RDATA(par_rdata), .PAR_ACK(par_ack), .PAR_BAD(par_bad), .RAMPING(ramping),
    .VEL_ZERO(vel_zero), .MOTION_CMD(motion_cmd), .RUN_CURRENT(run_current),
    .ACTUAL_POS(actual_pos), .DRV_FAULT(pins.fault), .DRV_LOAD(pins.load),
    .ROTOR_ANGLE(pins.angle), .STEP_IN(pins.step), .INT_ENC_A(pins.iq[1]),
    .INT_ENC_B(pins.iq[0]), .EXT_ENC_A(pins.xq[1]), .EXT_ENC_B(pins.xq[0]),
    .EXT_ENC_N(pins.xn), .CURRENT_SCALE(current_scale), .STANDBY_CURRENT(standby_current),
    .MOTOR_POWER_OFF(motor_power_off), .MOTOR_STOP(motor_stop));
  aesp_drv_model drv (.CORE_CLK(core_clk), .PINS(pins));

  // --------
  // Shared tasks
  // --------
  // Compare a value seen with the value expected.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // A request is held over one rising edge; the answer is settled by the next fall.
  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    @(negedge core_clk);
    par_wr = 1'b1;
    par_num = n;
    par_wdata = d;
    @(negedge core_clk);
    par_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] n);
    @(negedge core_clk);
    par_rd = 1'b1;
    par_num = n;
    @(negedge core_clk);
    par_rd = 1'b0;
    rd_val = par_rdata;
    rd_bad = par_bad;
  endtask
  task automatic rc(input logic [7:0] n, input logic [31:0] e);
    rd(n);
    chk(rd_val, e);
  endtask
  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang counts as a failure and still ends in the report.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  // --------
  // Main sequence
  // --------
  initial
  begin
    cyc(10);
    rst_n = 1'b1;
    for (i = 0; i < 9; i++)
      rc(rw_num[i], (rw_num[i] == aesp_pkg::P_STBY) ? 32'hC8 : 32'h0);
    for (i = 0; i < 9; i++)
    begin
      wr(rw_num[i], 32'hFFFF_FFFF);
      rc(rw_num[i], rw_mask[i]);
    end
    for (i = 0; i < 4; i++)
    begin
      wr(ro_num[i], 32'hFFFF_FFFF);
      rc(ro_num[i], ro_exp[i]);
    end
    rd(8'hC0);
    chk({31'h0, rd_bad}, 32'h1);
    $display("Test registers done");
    // A second reset in mid-run restores all values.
    rst_n = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    rc(aesp_pkg::P_STBY, 32'hC8);
    rc(aesp_pkg::P_XSCALE, 32'h0);
    wr(aesp_pkg::P_BOOST, 32'h40);
    ramping = 1'b1;
    cyc(2);
    chk(current_scale, 8'h40);
    ramping = 1'b0;
    cyc(2);
    chk(current_scale, 8'h20);
    wr(aesp_pkg::P_BOOST, 32'h0);
    ramping = 1'b1;
    cyc(2);
    chk(current_scale, 8'h20);
    ramping = 1'b0;
    $display("Test boost done");
    drv.p.load = 10'h3A5;
    drv.p.angle = 10'h2C1;
    cyc(12);
    rc(aesp_pkg::P_LOAD, 32'h3A5);
    rc(aesp_pkg::P_ANGLE, 32'h2C1);
    for (i = 0; i < 7; i++)
    begin
      drv.p.fault = 7'(1 << i);
      cyc(6);
      rc(aesp_pkg::P_DRV_FLT, 32'h80 | (32'h1 << i));
    end
    drv.p.fault = 7'h0;
    for (i = 0; i < 4; i++)
      drv.step_pulse();
    rc(aesp_pkg::P_DRV_FLT, 32'h0);
    cyc(40);
    rc(aesp_pkg::P_DRV_FLT, 32'h80);
    $display("Test faults done");
    rc(aesp_pkg::P_XERR, 32'h1);
    rc(aesp_pkg::P_XERR, 32'h0);
    wr(aesp_pkg::P_IDEV, 32'h5);
    actual_pos = 32'h6;
    cyc(4);
    chk(motor_stop, 1'b1);
    drv.p.fault = 7'h1;
    cyc(6);
    rc(aesp_pkg::P_XERR, 32'h3);
    actual_pos = 32'h5;
    drv.p.fault = 7'h0;
    rd(aesp_pkg::P_XERR);
    cyc(6);
    drv.p.fault = 7'h1;
    cyc(6);
    motion_cmd = 1'b1;
    cyc(1);
    motion_cmd = 1'b0;
    cyc(1);
    chk(motor_stop, 1'b0);
    rc(aesp_pkg::P_XERR, 32'h0);
    wr(aesp_pkg::P_IDEV, 32'h0);
    actual_pos = 32'h64;
    cyc(4);
    chk(motor_stop, 1'b0);
    $display("Test errors done");
    drv.quad(8, 1'b0);
    rc(aesp_pkg::P_IENC, 32'h8);
    wr(aesp_pkg::P_XENC, 32'h100);
    wr(aesp_pkg::P_NULL_CFG, 32'h5);
    drv.p.xn = 1'b1;
    cyc(6);
    rc(aesp_pkg::P_XENC, 32'h0);
    drv.p.xn = 1'b0;
    cyc(6);
    rc(aesp_pkg::P_NULL_CFG, 32'h4);
    wr(aesp_pkg::P_XENC, 32'h55);
    drv.null_pulse(1'b1);
    rc(aesp_pkg::P_XENC, 32'h55);
    drv.p.xn = 1'b1;
    wr(aesp_pkg::P_NULL_CFG, 32'h3);
    for (i = 0; i < 2; i++)
    begin
      wr(aesp_pkg::P_XENC, 32'h55);
      drv.p.xn = 1'b0;
      cyc(6);
      rc(aesp_pkg::P_XENC, 32'h0);
      drv.p.xn = 1'b1;
      cyc(6);
    end
    drv.quad(4, 1'b1);
    rc(aesp_pkg::P_XENC, 32'h4);
    $display("Test encoders done");
    wr(aesp_pkg::P_STBY, 32'h2);
    wr(aesp_pkg::P_FREEWHEEL, 32'h4);
    vel_zero = 1'b1;
    cyc(12);
    chk({standby_current, motor_power_off}, 2'b00);
    cyc(20);
    chk({standby_current, motor_power_off}, 2'b10);
    cyc(6);
    chk({standby_current, motor_power_off}, 2'b10);
    cyc(17);
    chk({standby_current, motor_power_off}, 2'b01);
    vel_zero = 1'b0;
    cyc(1);
    chk({standby_current, motor_power_off}, 2'b00);
    wr(aesp_pkg::P_FREEWHEEL, 32'h0);
    vel_zero = 1'b1;
    cyc(60);
    chk({standby_current, motor_power_off}, 2'b10);
    vel_zero = 1'b0;
    $display("Test power done");
    final_report();
  end
endmodule
